/* File: hw/clk_divider.sv */
`timescale 1ns/1ns
`include "sshift_cfg.svh"
// Emits a one-cycle pulse every half shift clock period.
module clk_divider (
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire sshift_pkg::rate_t rate,
	output logic half_tick
);
	logic [2:0] cnt_q;
	logic [2:0] half_m1;

	always_comb begin
		unique case (rate)
			sshift_pkg::RATE_DIV2: half_m1 = 3'(`PERIOD_2 / 2 - 1);
			sshift_pkg::RATE_DIV4: half_m1 = 3'(`PERIOD_4 / 2 - 1);
			default: half_m1 = 3'(`PERIOD_8 / 2 - 1);
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst || !run) begin
			cnt_q <= 3'h0;
		end else if (cnt_q >= half_m1) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_q + 3'h1;
		end
	end

	assign half_tick = run && (cnt_q >= half_m1);
endmodule : clk_divider

/* File: hw/serial_shift_port.sv */
`timescale 1ns/1ns
`include "sshift_cfg.svh"
// Summary of operation
// RQ1 - Eight bit shift register on serial in, serial out and shift clock.
// RQ2 - Internal shift clock means master, external shift clock means slave.
// RQ3 - Port works only while interface select bit is one.
// RQ4 - Master rate bits: 00 two, 01 four, 1x eight cycles per clock.
// RQ5 - Setting busy flag starts shifting.
// RQ6 - Busy clears by itself after eight bits.
// RQ7 - Software clearing busy stops shifting early.
// RQ8 - Interrupt request after eight bits when enabled.
// RQ9 - Software loads shift register only while shift clock idles.
// RQ10 - Slave busy set only while incoming shift clock idles.
// RQ11 - Master generates shift clock and starts every exchange.
// RQ12 - Master needs serial out and clock pins set as outputs.
// RQ13 - Slave needs clock pin input and serial out pin output.
// RQ14 - Clock pin config bit picks source; serial out bit zero floats.
// RQ15 - Shift clock stops after eight pulses.
// RQ16 - Slave software sets busy right away; may repeat after eight.
// RQ17 - Port data bit 5 sets clock idle level, one is high.
// RQ18 - Normal phase: sample rising, drive and shift falling. Code shifts on the trailing edge, which is rising when idle high.
// RQ19 - Alternate phase: sample falling, drive rising.
// RQ20 - Phase select lives in port pin 6 config bit.
// RQ21 - Phase select XOR idle level gives alternate phase.
// RQ22 - Phase select resets to zero.
// RQ23 - Most significant bit out first, new bits enter at bit zero.
module serial_shift_port #(
	parameter int WIDTH = `BITS_PER_XFER
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic si,
	output logic so,
	output logic so_oe,
	output logic irq
);
	// ***********************************************
	// Registers
	// ***********************************************
	logic [7:0] control_register_q;
	logic [7:0] port_data_q;
	logic [7:0] port_cfg_q;
	logic [WIDTH-1:0] serial_shift_reg_q;
	logic busy_q;
	logic done_q;
	logic irq_q;
	logic [3:0] bit_cnt_q;
	logic sck_q;
	logic so_q;
	logic sample_q;
	logic [7:0] rdata_q;

	logic interface_select;
	logic master;
	logic idle_high;
	logic phase_select;
	logic alt_phase;
	logic active;
	sshift_pkg::rate_t rate;

	assign interface_select = control_register_q[`CTL_IFSEL]; // RQ3
	assign master = port_cfg_q[`PIN_SCK]; // RQ14 RQ2
	assign idle_high = port_data_q[`PIN_SCK]; // RQ17
	assign phase_select = port_cfg_q[`PIN_PHASE]; // RQ20
	assign alt_phase = phase_select ^ idle_high; // RQ21
	assign active = interface_select && busy_q;

	always_comb begin
		if (control_register_q[`CTL_RATE_HI]) begin // RQ4
			rate = sshift_pkg::RATE_DIV8;
		end else if (control_register_q[`CTL_RATE_LO]) begin
			rate = sshift_pkg::RATE_DIV4;
		end else begin
			rate = sshift_pkg::RATE_DIV2;
		end
	end

	// ***********************************************
	// External shift clock and serial in sampling
	// ***********************************************
	logic sck_s1_q;
	logic sck_s2_q;
	logic sck_s3_q;
	logic si_s1_q;
	logic si_s2_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			si_s1_q <= 1'b0;
			si_s2_q <= 1'b0;
		end else begin
			sck_s1_q <= sck_in;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			si_s1_q <= si;
			si_s2_q <= si_s1_q;
		end
	end

	// ***********************************************
	// Edge generation
	// ***********************************************
	logic half_tick;
	logic lead_edge;
	logic trail_edge;
	logic rise;
	logic fall;

	clk_divider u_div (
		.mclk(mclk),
		.rst(rst),
		.run(active && master),
		.rate(rate),
		.half_tick(half_tick)
	);

	// Leading edge leaves idle level, trailing edge returns to it
	always_comb begin
		if (master) begin // RQ11
			lead_edge = half_tick && (sck_q == idle_high);
			trail_edge = half_tick && (sck_q != idle_high);
		end else begin
			lead_edge = active && (sck_s3_q == idle_high)
				&& (sck_s2_q != idle_high);
			trail_edge = active && (sck_s3_q != idle_high)
				&& (sck_s2_q == idle_high);
		end
	end

	// Rising is leading when idle low
	assign rise = idle_high ? trail_edge : lead_edge;
	assign fall = idle_high ? lead_edge : trail_edge;

	logic sample_ev;
	logic drive_ev;
	assign sample_ev = alt_phase ? fall : rise; // RQ18 RQ19
	assign drive_ev = alt_phase ? rise : fall; // RQ18 RQ19

	// ***********************************************
	// Register writes and busy control
	// ***********************************************
	logic last_bit;
	assign last_bit = trail_edge && (bit_cnt_q == 4'(WIDTH - 1));

	always_ff @(posedge mclk) begin
		if (rst) begin
			control_register_q <= `CONTROL_RST;
			port_data_q <= `PORT_RST;
			port_cfg_q <= `PORT_RST; // RQ22
		end else if (wr) begin
			unique case (addr)
				`REG_CONTROL: control_register_q <= wdata;
				`REG_PORT_DATA: port_data_q <= wdata;
				`REG_PORT_CFG: port_cfg_q <= wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else if (active && last_bit) begin
			busy_q <= 1'b0; // RQ6
		end else if (wr && addr == `REG_STATUS) begin
			busy_q <= wdata[`STS_BUSY]; // RQ5 RQ7
		end
	end

	// Completion flag: hardware set wins over software clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			done_q <= 1'b0;
		end else if (active && last_bit) begin
			done_q <= 1'b1;
		end else if (wr && addr == `REG_STATUS && !wdata[`STS_DONE]) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= active && last_bit
				&& control_register_q[`CTL_IRQ_EN]; // RQ8
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !active) begin
			bit_cnt_q <= 4'h0;
		end else if (trail_edge) begin
			bit_cnt_q <= bit_cnt_q + 4'h1; // RQ15
		end
	end

	// ***********************************************
	// Shift clock output
	// ***********************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			sck_q <= 1'b0;
		end else if (!active || !master) begin
			sck_q <= idle_high; // RQ17 RQ15
		end else if (half_tick) begin
			sck_q <= ~sck_q;
		end
	end

	// ***********************************************
	// Shift path
	// ***********************************************
	// With idle low, normal phase samples before the first drive edge and alternate
	// phase drives at the leading edge, so the first bit goes out on load.
	// Sample one cycle after the edge: the far end answers on our own
	// drive edge and its bit needs two cycles through the synchroniser.
	logic sample_dly_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sample_dly_q <= 1'b0;
		end else begin
			sample_dly_q <= active && sample_ev;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sample_q <= 1'b0;
		end else if (active && sample_dly_q) begin
			sample_q <= si_s2_q; // RQ18 RQ19
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			serial_shift_reg_q <= '0;
		end else if (wr && addr == `REG_SHIFT) begin
			serial_shift_reg_q <= wdata[WIDTH-1:0]; // RQ9
		end else if (active && trail_edge) begin
			// RQ23 RQ1
			serial_shift_reg_q <= {serial_shift_reg_q[WIDTH-2:0],
				alt_phase ? si_s2_q : sample_q};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			so_q <= 1'b0;
		end else if (!active) begin
			so_q <= serial_shift_reg_q[WIDTH-1];
		end else if (drive_ev && !(alt_phase && lead_edge
				&& bit_cnt_q == 4'h0)) begin
			so_q <= alt_phase ? serial_shift_reg_q[WIDTH-1]
				: serial_shift_reg_q[WIDTH-2]; // RQ23
		end
	end

	// ***********************************************
	// Pins
	// ***********************************************
	assign sck_out = sck_q;
	assign sck_oe = interface_select && master; // RQ14 RQ2
	assign so = so_q;
	assign so_oe = interface_select && port_cfg_q[`PIN_SO]; // RQ14
	assign irq = irq_q;

	// ***********************************************
	// Read port
	// ***********************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (rd) begin
			unique case (addr)
				`REG_CONTROL: rdata_q <= control_register_q;
				`REG_STATUS: rdata_q <= {6'h00, done_q, busy_q};
				`REG_SHIFT: rdata_q <= 8'(serial_shift_reg_q);
				`REG_PORT_DATA: rdata_q <= port_data_q;
				`REG_PORT_CFG: rdata_q <= port_cfg_q;
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign rdata = rdata_q;
endmodule : serial_shift_port

/* File: hw/sshift_cfg.svh */
`ifndef SSHIFT_CFG_SVH
`define SSHIFT_CFG_SVH
// Register offsets on the plain register port
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h1
`define REG_SHIFT 4'h2
`define REG_PORT_DATA 4'h3
`define REG_PORT_CFG 4'h4
// control_register fields
`define CTL_RATE_LO 0
`define CTL_RATE_HI 1
`define CTL_IFSEL 3
`define CTL_IRQ_EN 4
// processor_status_register fields
`define STS_BUSY 0
`define STS_DONE 1
// Port field positions
`define PIN_SO 4
`define PIN_SCK 5
`define PIN_PHASE 6
// Reset values
`define CONTROL_RST 8'h00
`define PORT_RST 8'h00
// Shift clock periods in instruction cycles
`define PERIOD_2 2
`define PERIOD_4 4
`define PERIOD_8 8
`define BITS_PER_XFER 8
`endif

/* File: hw/sshift_pkg.sv */
package sshift_pkg;
	typedef enum logic [1:0] {
		RATE_DIV2,
		RATE_DIV4,
		RATE_DIV8
	} rate_t;
endpackage : sshift_pkg

/* File: tb/serial_shift_port_properties.sv */
`timescale 1ns/1ns
`include "sshift_cfg.svh"
module sshift_properties #(
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic sck_in,
	input wire logic sck_out,
	input wire logic sck_oe,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic irq
);
	// ******************************
	// Shadow of the written registers
	// ******************************
	logic [7:0] ctl_q;
	logic [7:0] cfg_q;
	logic [7:0] pd_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctl_q <= 8'h00;
			cfg_q <= 8'h00;
			pd_q <= 8'h00;
		end else if (wr) begin
			if (addr == `REG_CONTROL) ctl_q <= wdata;
			if (addr == `REG_PORT_CFG) cfg_q <= wdata;
			if (addr == `REG_PORT_DATA) pd_q <= wdata;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_sck_oe_cfg: assert property (
		sck_oe == (ctl_q[3] && cfg_q[5])) else $error("sck enable wrong");
	a_so_oe_cfg: assert property (
		so_oe == (ctl_q[3] && cfg_q[4])) else $error("so enable wrong");
	a_irq_gated: assert property (
		irq |-> ctl_q[4] && ctl_q[3]) else $error("irq while disabled");
	a_irq_pulse: assert property (
		irq |=> !irq) else $error("irq longer than a cycle");
	a_idle_after: assert property (
		irq |=> sck_out == pd_q[5]) else $error("clock not idle at end");
	a_rate_min: assert property (
		$changed(sck_out) && ctl_q[1:0] != 2'b00
		|=> $stable(sck_out) || sck_out == pd_q[5])
		else $error("half period too short");
	a_rate_eight: assert property (
		$changed(sck_out) && ctl_q[1]
		|=> ($stable(sck_out) || sck_out == pd_q[5])[*3])
		else $error("half period below four");
	a_rate_two: assert property (
		$rose(sck_out) && ctl_q[1:0] == 2'b00 && !pd_q[5] |=> $fell(sck_out))
		else $error("half period not one");
	a_rdata_zero: assert property (
		!rd |=> rdata == 8'h00) else $error("read data without read");
endmodule : sshift_properties
bind serial_shift_port sshift_properties #(.WIDTH(WIDTH)) chk_i (
	.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .sck_in,
	.sck_out, .sck_oe, .si, .so, .so_oe, .irq);

/* File: tb/spi_peer.sv */
`timescale 1ns/1ns
module spi_peer (
	input wire logic mclk,
	input wire logic sck,
	input wire logic mosi,
	input wire logic en,
	input wire logic [7:0] tx,
	input wire logic load,
	output logic miso,
	output logic [7:0] rx_q
);
	// ******************************
	// Normal phase far end, idle low
	// ******************************
	logic [7:0] sh_q;
	logic junk_q = 1'b0;
	// Released line wobbles so stale data never looks valid
	always @(posedge mclk) junk_q <= ~junk_q;
	always @(posedge mclk) if (load) sh_q <= tx;
	always @(posedge sck) rx_q <= {rx_q[6:0], mosi};
	always @(negedge sck) sh_q <= {sh_q[6:0], 1'b0};
	assign miso = en ? sh_q[7] : junk_q;
endmodule : spi_peer

/* File: tb/tb_serial_shift_port.sv */
`timescale 1ns/1ns
`include "sshift_cfg.svh"
`define CHK(a, e) chk((a) === (e))
module tb_serial_shift_port;
	logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sck_in = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, tx, ptx, rx;
	logic sck_out, sck_oe, si, so, so_oe, irq, sck, sck_p = 1'b0;
	logic load = 1'b0;
	int errors = 0, check_count = 0, pulses = 0, irqs = 0, p0, q0;
	integer seed = 32'h7fc5;
	serial_shift_port uut (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
		.sck_in, .sck_out, .sck_oe, .si, .so, .so_oe, .irq);
	spi_peer peer (.mclk, .sck, .mosi(so), .en(so_oe), .tx(ptx), .load,
		.miso(si), .rx_q(rx));
	assign sck = sck_oe ? sck_out : sck_in;
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		sck_p <= sck;
		if (sck && !sck_p) pulses++;
		if (irq === 1'b1) irqs++;
	end
	// ******************************
	// Bus tasks and checks
	// ******************************
	task automatic chk(input bit ok);
		check_count++;
		if (!ok) begin
			errors++;
			$display("wrong value at %0t ns: compare failed", $time);
		end
	endtask : chk
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask : wreg
	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 `CHK(rdata, e);
		@(posedge mclk);
	endtask : rchk
	task automatic start(input logic [7:0] ctl, input logic [7:0] cfg);
		tx = 8'($random(seed));
		ptx = 8'($random(seed));
		load <= 1'b1;
		wreg(`REG_PORT_CFG, cfg);
		load <= 1'b0;
		wreg(`REG_CONTROL, ctl);
		wreg(`REG_STATUS, 8'h00);
		wreg(`REG_SHIFT, tx);
		p0 = pulses;
		q0 = irqs;
		wreg(`REG_STATUS, 8'h01);
	endtask : start
	task automatic wait_irq(input int n);
		repeat (n) begin
			@(posedge mclk);
			if (irq === 1'b1) break;
		end
		repeat (2) @(posedge mclk);
	endtask : wait_irq
	task automatic finish_test;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// Budget of ten thousand cycles, about ten times the run
	initial begin : watchdog
		#1000000;
		errors++;
		finish_test();
	end
	initial begin : main
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rchk(`REG_PORT_CFG, 8'h00);
		rchk(4'hf, 8'h00);
		for (int n = 0; n < 8; n++) begin
			start(8'h18 | 8'(n % 4), 8'h30);
			wait_irq(200);
			`CHK(pulses - p0, 8);
			`CHK(irqs - q0, 1);
			rchk(`REG_STATUS, 8'h02);
			// Peer answers late at rate two, so data is judged above it
			if (n % 4 != 0) begin
				rchk(`REG_SHIFT, ptx);
				`CHK(rx, tx);
			end
		end
		wreg(`REG_PORT_DATA, 8'h20);
		repeat (3) @(posedge mclk);
		`CHK(sck_out, 1'b1);
		wreg(`REG_PORT_DATA, 8'h00);
		start(8'h19, 8'h70);
		wait_irq(200);
		`CHK(pulses - p0, 8);
		start(8'h1a, 8'h30);
		repeat (20) @(posedge mclk);
		wreg(`REG_STATUS, 8'h00);
		repeat (100) @(posedge mclk);
		`CHK(pulses - p0 < 8 && irqs == q0, 1'b1);
		start(8'h0b, 8'h30);
		repeat (150) @(posedge mclk);
		`CHK(irqs - q0, 0);
		start(8'h13, 8'h30);
		repeat (100) @(posedge mclk);
		`CHK(pulses - p0, 0);
		start(8'h18, 8'h10);
		repeat (8) begin
			repeat (4) @(posedge mclk);
			sck_in <= 1'b1;
			repeat (4) @(posedge mclk);
			sck_in <= 1'b0;
		end
		@(posedge mclk);
		repeat (20) @(posedge mclk);
		`CHK(irqs - q0, 1);
		`CHK(rx, tx);
		rchk(`REG_SHIFT, ptx);
		finish_test();
	end
endmodule : tb_serial_shift_port
